// >>> hw/clock_source_select_pll.sv
// Purpose: clock source decode, pll control, start-up timing and clock gating
// Assumes: all inputs synchronous to aclk; ticks are one-cycle pulses per source period
// Notes: clocks are modelled as enables and rate reports, not generated here
`timescale 1ns/100ps
`include "clock_source_select_pll_defines.svh"

module clock_source_select_pll #(
    parameter int SETTLE_SHORT = `WDT_CYCLES_4MS,
    parameter int SETTLE_LONG = `WDT_CYCLES_64MS,
    parameter int PLL_CK_SHORT = `PLL_CK_SHORT,
    parameter int PLL_CK_LONG = `PLL_CK_LONG,
    parameter int LOCK_CYCLES = `PLL_LOCK_CYCLES,
    parameter int ASYNC_INTS = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fuse straps, caught once after reset release
    input wire clock_source_select_pll_pkg::fuse_s fuses,
    // one-cycle ticks of the selected source and of the watchdog oscillator
    input wire logic source_tick,
    input wire logic wdt_tick,
    // wake sources
    input wire logic wake_event,
    input wire logic [ASYNC_INTS-1:0] async_int_in,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // clock gates and pin ownership
    output clock_source_select_pll_pkg::gate_s gates,
    // system source and rates
    output clock_source_select_pll_pkg::src_e sys_source,
    output logic [1:0] xtal_range,
    output logic prescale_by_eight,
    output logic pll_ref_halved,
    output logic [16:0] pll_fast_khz,
    output logic [16:0] pll_sys_khz,
    output logic timer_fast_clock_ok,
    output logic [7:0] rc_calibration_value,
    output logic cpu_running,
    output logic async_int_wake
);
    import clock_source_select_pll_pkg::*;

    typedef struct packed {
        seq_e st;
        logic [14:0] cnt;
        logic from_reset;
        fuse_s fuse;
        logic pll_enable_bit;
        logic pll_low_speed;
        logic pll_lock_flag;
        logic [11:0] lock_cnt;
        logic [7:0] rc_cal;
        sleep_e sleep_mode;
        gate_s gates;
        logic [16:0] fast_khz;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s q;
    state_s d;

    // decode of the four-bit select code, raw fuse levels
    function automatic src_e decode_src(input logic [3:0] code);
        src_e s;
        s = SRC_XTAL; // 1xxx
        if (code[3:2] == 2'b01)
            s = SRC_LFXT;
        else if (code == `CODE_EXT_CLOCK)
            s = SRC_EXT;
        else if (code == `CODE_PLL)
            s = SRC_PLL;
        else if (code == `CODE_RC)
            s = SRC_RC;
        else if (code == `CODE_WDT_OSC)
            s = SRC_WDT;
        return s;
    endfunction

    src_e src;
    logic pll_is_sys;
    logic deep_sleep;
    logic wake;
    logic [14:0] settle_cnt;
    logic [14:0] pll_src_cnt;
    logic [14:0] pll_wait_cnt;
    logic wr_fire;
    logic sleep_enter;

    assign src = decode_src(q.fuse.clock_select_fuses);
    assign pll_is_sys = (src == SRC_PLL);
    assign deep_sleep = (q.st == S_SLEEP) &&
        (q.sleep_mode == SLP_POWER_DOWN || q.sleep_mode == SLP_STANDBY);
    // interrupt detect path needs no clock at all, so it is plain gates
    assign async_int_wake = |async_int_in;
    assign wake = wake_event | async_int_wake;

    // start-up lengths from the caught start-up code
    always_comb
    begin
        if (pll_is_sys)
            settle_cnt = 15'(SETTLE_SHORT);
        else
        begin
            case (q.fuse.startup_select_fuses)
                2'b00: settle_cnt = 15'h0000;
                2'b01: settle_cnt = 15'(SETTLE_SHORT);
                default: settle_cnt = 15'(SETTLE_LONG);
            endcase
        end
        pll_src_cnt = `SRC_CK_RESET_EXTRA +
            (q.fuse.startup_select_fuses[0] ? 15'(PLL_CK_LONG) : 15'(PLL_CK_SHORT));
        pll_wait_cnt = q.fuse.startup_select_fuses[1] ? 15'(SETTLE_LONG) : 15'(SETTLE_SHORT);
    end

    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign sleep_enter = wr_fire && (q.aw_addr == `OFS_SLEEP_CONTROL) && q.w_lane0 &&
        q.w_byte[`BIT_SLEEP_ENTER];

    // the whole next-state logic
    always_comb
    begin
        d = q;

        // start-up sequencer
        case (q.st)
            S_RESET:
            begin
                d.fuse = fuses; // straps caught after release, never under reset
                d.from_reset = 1'b1;
                d.st = S_SETTLE;
                d.cnt = 15'h0000;
            end
            S_SETTLE:
            begin
                if (q.cnt >= settle_cnt)
                begin
                    d.st = S_SRC;
                    d.cnt = 15'h0000;
                end
                else if (wdt_tick)
                    d.cnt = q.cnt + 15'h0001;
            end
            S_SRC:
            begin
                if ((pll_is_sys && q.cnt >= pll_src_cnt) ||
                    (!pll_is_sys && q.cnt >= (q.from_reset ?
                        `SRC_CK_WAKE + `SRC_CK_RESET_EXTRA : `SRC_CK_WAKE)))
                begin
                    d.st = pll_is_sys ? S_PLLWAIT : S_RUN;
                    d.cnt = 15'h0000;
                end
                else if (source_tick)
                    d.cnt = q.cnt + 15'h0001;
            end
            S_PLLWAIT:
            begin
                if (q.cnt >= pll_wait_cnt)
                    d.st = S_RUN;
                else if (wdt_tick)
                    d.cnt = q.cnt + 15'h0001;
            end
            S_RUN:
            begin
                d.from_reset = 1'b0;
                if (sleep_enter)
                begin
                    d.st = S_SLEEP;
                    d.sleep_mode = sleep_e'(q.w_byte[`BIT_SLEEP_MODE_LO +: 2]);
                end
            end
            S_SLEEP:
            begin
                if (wake)
                begin
                    d.cnt = 15'h0000;
                    // light sleeps keep the oscillators, so no start-up is counted
                    d.st = deep_sleep ? S_SRC : S_RUN;
                end
            end
            default:
                d.st = S_RESET;
        endcase

        // lock timer restarts whenever the multiplier is stopped
        if (q.gates.pll_on)
        begin
            if (q.lock_cnt >= 12'(LOCK_CYCLES))
                d.pll_lock_flag = 1'b1;
            else
                d.lock_cnt = q.lock_cnt + 12'h001;
        end
        else
        begin
            d.lock_cnt = 12'h000;
            d.pll_lock_flag = 1'b0;
        end
        // axi4-lite write side, address and data in either order
        if (!q.aw_got && awvalid)
        begin
            d.aw_got = 1'b1;
            d.aw_addr = awaddr;
        end
        if (!q.w_got && wvalid)
        begin
            d.w_got = 1'b1;
            d.w_byte = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end
        if (wr_fire)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            case (q.aw_addr)
                `OFS_PLL_CONTROL_STATUS:
                    if (q.w_lane0)
                    begin
                        d.pll_enable_bit = q.w_byte[`BIT_PLL_ENABLE];
                        // low-speed may always be cleared, set only off the system path
                        d.pll_low_speed = q.w_byte[`BIT_PLL_LOW_SPEED] && !pll_is_sys;
                    end
                `OFS_RC_CALIBRATION:
                    if (q.w_lane0)
                        d.rc_cal = q.w_byte;
                `OFS_SLEEP_CONTROL, `OFS_CLOCK_STATUS:
                    d.bresp = 2'b00; // status is read-only, write ignored
                default:
                    d.bresp = 2'b10;
            endcase
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;
        // axi4-lite read side
        if (!q.rvalid && arvalid)
        begin
            d.rvalid = 1'b1;
            d.rresp = 2'b00;
            d.rdata = 32'h0000_0000;
            case (araddr)
                `OFS_PLL_CONTROL_STATUS:
                    d.rdata[`BIT_PLL_LOW_SPEED:`BIT_PLL_LOCK] =
                        {q.pll_low_speed, q.pll_enable_bit, q.pll_lock_flag};
                `OFS_RC_CALIBRATION:
                    d.rdata[7:0] = q.rc_cal;
                `OFS_SLEEP_CONTROL:
                    d.rdata[`BIT_SLEEP_MODE_LO +: 2] = q.sleep_mode;
                `OFS_CLOCK_STATUS:
                    d.rdata[23:0] = {q.gates, 2'b00, q.st, 1'b0, q.fuse};
                default:
                    d.rresp = 2'b10;
            endcase
        end
        else if (q.rvalid && rready)
            d.rvalid = 1'b0;

        // gates follow the next sequencer state so they come straight from flops
        d.gates.core_clock = (d.st == S_RUN);
        d.gates.program_memory_clock = d.gates.core_clock;
        d.gates.peripheral_io_clock = (d.st == S_RUN) ||
            (d.st == S_SLEEP && d.sleep_mode == SLP_IDLE);
        // converter domain stays up through idle and noise reduction
        d.gates.converter_clock = (d.st == S_RUN) || (d.st == S_SLEEP &&
            (d.sleep_mode == SLP_IDLE || d.sleep_mode == SLP_NOISE));
        d.gates.rc_osc_on = !(d.st == S_SLEEP &&
            (d.sleep_mode == SLP_POWER_DOWN || d.sleep_mode == SLP_STANDBY));
        d.gates.pll_on = d.gates.rc_osc_on &&
            (d.pll_enable_bit || d.fuse.clock_select_fuses == `CODE_PLL);
        d.gates.port_pin_four_clock_in = (decode_src(d.fuse.clock_select_fuses) == SRC_EXT) ||
            d.fuse.clock_select_fuses[3] || (d.fuse.clock_select_fuses[3:2] == 2'b01);
        d.gates.port_pin_five_osc_out = d.fuse.clock_select_fuses[3] ||
            (d.fuse.clock_select_fuses[3:2] == 2'b01);

        // rate report: eight times the reference, halved reference on low speed
        d.fast_khz = 17'(`RC_KHZ * `PLL_MULT) >> d.pll_low_speed;
    end

    // single state register; control state goes to shipped values on reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.st <= S_RESET;
            q.fuse <= {`RST_CLOCK_SELECT, `RST_STARTUP_SELECT, `RST_DIV8_FUSE};
            q.rc_cal <= `RST_RC_CAL;
            q.fast_khz <= 17'(`RC_KHZ * `PLL_MULT);
        end
        else
            q <= d;
    end

    // bus handshakes
    assign awready = !q.aw_got;
    assign wready = !q.w_got;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // clock outputs and rates
    assign gates = q.gates;
    assign sys_source = src;
    assign xtal_range = q.fuse.clock_select_fuses[3] ? q.fuse.clock_select_fuses[2:1] : 2'b00;
    // fuse bit at zero means programmed
    assign prescale_by_eight = !q.fuse.divide_by_eight_fuse;
    assign pll_ref_halved = q.pll_low_speed;
    assign pll_fast_khz = q.fast_khz;
    assign pll_sys_khz = q.fast_khz / 17'(`PLL_SYS_DIV);
    assign timer_fast_clock_ok = q.pll_lock_flag;
    assign rc_calibration_value = q.rc_cal;
    assign cpu_running = q.gates.core_clock;

endmodule // clock_source_select_pll

// >>> hw/clock_source_select_pll_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the clock block
// Assumes: 32-bit register bus, byte addresses
// Notes: fuse bit value one means unprogrammed, zero means programmed
`ifndef CLOCK_SOURCE_SELECT_PLL_DEFINES_SVH
`define CLOCK_SOURCE_SELECT_PLL_DEFINES_SVH

// register byte offsets
`define OFS_PLL_CONTROL_STATUS 8'h00
`define OFS_RC_CALIBRATION 8'h04
`define OFS_SLEEP_CONTROL 8'h08
`define OFS_CLOCK_STATUS 8'h0c

// pll_control_status fields
`define BIT_PLL_LOCK 0
`define BIT_PLL_ENABLE 1
`define BIT_PLL_LOW_SPEED 2
// sleep_control fields
`define BIT_SLEEP_MODE_LO 0
`define BIT_SLEEP_ENTER 4

// reset values; fuse copies hold the shipped setting until the straps are caught
`define RST_CLOCK_SELECT 4'h2
`define RST_STARTUP_SELECT 2'h2
`define RST_DIV8_FUSE 1'b0
`define RST_RC_CAL 8'h80

// fuse codes
`define CODE_EXT_CLOCK 4'h0
`define CODE_PLL 4'h1
`define CODE_RC 4'h2
`define CODE_WDT_OSC 4'h3

// nominal rates in kHz
`define RC_KHZ 17'd8000
`define PLL_MULT 5'd8
`define PLL_SYS_DIV 3'd4

// start-up counts (source clocks and watchdog oscillator cycles)
`define SRC_CK_WAKE 15'd6
`define SRC_CK_RESET_EXTRA 15'd14
`define WDT_CYCLES_4MS 512
`define WDT_CYCLES_64MS 8192
`define PLL_CK_SHORT 1024
`define PLL_CK_LONG 16384

// lock time of the multiplier
`define CLK_MHZ 25
`define PLL_LOCK_US 100
`define PLL_LOCK_CYCLES ((`PLL_LOCK_US) * (`CLK_MHZ))

`endif

// >>> hw/clock_source_select_pll_pkg.sv
// Purpose: types shared by the clock source and pll block
// Assumes: one clock domain
// Notes: counts and offsets live in the defines header
package clock_source_select_pll_pkg;

    typedef struct packed {
        logic [3:0] clock_select_fuses;
        logic [1:0] startup_select_fuses;
        logic divide_by_eight_fuse;
    } fuse_s;

    typedef struct packed {
        logic core_clock;
        logic peripheral_io_clock;
        logic program_memory_clock;
        logic converter_clock;
        logic rc_osc_on;
        logic pll_on;
        logic port_pin_four_clock_in;
        logic port_pin_five_osc_out;
    } gate_s;

    typedef enum logic [5:0] {
        SRC_EXT = 6'b000001,
        SRC_PLL = 6'b000010,
        SRC_RC = 6'b000100,
        SRC_WDT = 6'b001000,
        SRC_LFXT = 6'b010000,
        SRC_XTAL = 6'b100000
    } src_e;

    typedef enum logic [5:0] {
        S_RESET = 6'b000001,
        S_SETTLE = 6'b000010,
        S_SRC = 6'b000100,
        S_PLLWAIT = 6'b001000,
        S_RUN = 6'b010000,
        S_SLEEP = 6'b100000
    } seq_e;

    typedef enum logic [1:0] {
        SLP_IDLE = 2'h0,
        SLP_NOISE = 2'h1,
        SLP_POWER_DOWN = 2'h2,
        SLP_STANDBY = 2'h3
    } sleep_e;

endpackage

// >>> bench/clock_source_select_pll_assertions.sv
// Purpose: port-level checks for the clock source and pll block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the top module from the bench file
`timescale 1ns/100ps
module clock_source_select_pll_assertions #(
    parameter int ASYNC_INTS = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // observed inputs
    input wire logic [ASYNC_INTS-1:0] async_int_in,
    // observed outputs
    input wire clock_source_select_pll_pkg::gate_s gates,
    input wire clock_source_select_pll_pkg::src_e sys_source,
    input wire logic pll_ref_halved,
    input wire logic [16:0] pll_fast_khz,
    input wire logic [16:0] pll_sys_khz,
    input wire logic timer_fast_clock_ok,
    input wire logic async_int_wake
);
    import clock_source_select_pll_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // oscillator and core both stopped: reset or deep sleep
    sequence core_halted_deep;
        !gates.rc_osc_on && !gates.core_clock;
    endsequence

    // rate outputs move in the same cycle as the low-speed bit
    fast_rate_a: assert property (
        pll_fast_khz == (pll_ref_halved ? 17'd32000 : 17'd64000)) else $error("fast rate wrong");
    sys_rate_a: assert property (
        pll_sys_khz == (pll_ref_halved ? 17'd8000 : 17'd16000)) else $error("system rate wrong");
    low_speed_block_a: assert property (sys_source == SRC_PLL |-> !pll_ref_halved)
        else $error("low speed set on pll source");
    pll_select_on_a: assert property (
        sys_source == SRC_PLL && gates.rc_osc_on |-> gates.pll_on) else $error("pll not on");
    deep_off_a: assert property (!gates.rc_osc_on |-> !gates.pll_on)
        else $error("pll runs without oscillator");
    lock_after_on_a: assert property (
        $rose(timer_fast_clock_ok) |-> gates.pll_on && $past(gates.pll_on, 4))
        else $error("lock too early");
    lock_drop_a: assert property ($fell(gates.pll_on) |=> !timer_fast_clock_ok)
        else $error("lock kept after pll off");
    flash_core_a: assert property (
        gates.program_memory_clock == gates.core_clock) else $error("flash clock apart");
    pin_pair_a: assert property (
        gates.port_pin_five_osc_out |-> gates.port_pin_four_clock_in) else $error("pin five alone");
    async_wake_a: assert property (async_int_wake == (|async_int_in))
        else $error("async wake wrong");
    deep_hold_a: assert property (core_halted_deep |=> !gates.core_clock)
        else $error("core started without count");
endmodule // clock_source_select_pll_assertions

// >>> bench/clock_source_select_pll_bench.sv
// Purpose: self-checking bench for the clock source and pll block
// Assumes: short start-up and lock counts set at the instance
// Notes: source and watchdog ticks are one per aclk while enabled
`timescale 1ns/100ps
module clock_source_select_pll_bench;
    import clock_source_select_pll_pkg::*;
    logic aclk = 0, aresetn = 0, source_tick = 1, wdt_tick = 1, wake_event = 0;
    fuse_s fuses = 7'h14;
    logic [1:0] async_int_in = 0, bresp, rresp, xtal_range;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, rc_calibration_value;
    logic [31:0] wdata = 0, rdata, q;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, prescale_by_eight, pll_ref_halved;
    logic timer_fast_clock_ok, cpu_running, async_int_wake;
    logic [16:0] pll_fast_khz, pll_sys_khz;
    gate_s gates;
    src_e sys_source;
    int err_total = 0, checked = 0, cycles = 0, base_n, n;

    clock_source_select_pll #(.SETTLE_SHORT(4), .SETTLE_LONG(8), .PLL_CK_SHORT(4),
        .PLL_CK_LONG(8), .LOCK_CYCLES(5)) i_dut (.aclk, .aresetn, .fuses, .source_tick,
        .wdt_tick, .wake_event, .async_int_in, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .gates, .sys_source, .xtal_range, .prescale_by_eight, .pll_ref_halved,
        .pll_fast_khz, .pll_sys_khz, .timer_fast_clock_ok, .rc_calibration_value,
        .cpu_running, .async_int_wake);

    // 25 MHz clock
    always #20 aclk = ~aclk;

    // hang guard, well above the roughly 1100 cycles the run needs
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one axi4-lite transfer; every signal moves by nba just after a rising edge,
    // and each handshake is judged on the values that stood at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1)
                awvalid <= 0;
            if (wvalid && wready === 1'b1)
                wvalid <= 0;
            if (arvalid && arready === 1'b1)
                arvalid <= 0;
            done = wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
            q = rdata;
            r = wr ? bresp : rresp;
            if (done)
            begin
                bready <= 0;
                rready <= 0;
            end
        end
    endtask

    // reset with given straps, then count cycles from release until the core runs
    task automatic start(input logic [3:0] c, input logic [1:0] s, input logic d8,
        output int cnt);
        @(posedge aclk);
        fuses <= {c, s, d8};
        aresetn <= 0;
        source_tick <= 1;
        repeat (8) @(posedge aclk);
        check("ship_src", sys_source, 32'h4);
        check("ship_div8", prescale_by_eight, 1'b1);
        aresetn <= 1;
        cnt = 0;
        @(negedge aclk);
        while (cpu_running !== 1'b1 && cnt < 400)
        begin
            @(negedge aclk);
            cnt++;
        end
    endtask

    task automatic test_decode();
        logic [3:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            start(c, 2'b00, 1'b1, n);
            check("source", sys_source, c == 0 ? 1 : c == 1 ? 2 : c == 2 ? 4 : c == 3 ? 8 :
                c[3] ? 32 : 16);
            check("range", xtal_range, c[3] ? c[2:1] : 2'h0);
            check("pin_four", gates.port_pin_four_clock_in, c == 0 || c[3:2] != 0);
            check("pin_five", gates.port_pin_five_osc_out, c[3:2] != 0);
            check("prescale", prescale_by_eight, 1'b0);
        end
    endtask

    task automatic test_startup();
        int r[4], p[4];
        for (int i = 0; i < 4; i++)
        begin
            start(4'h2, i[1:0], 1'b0, r[i]);
            start(4'h1, i[1:0], 1'b0, p[i]);
        end
        base_n = r[0];
        check("rc_sut01", r[1] - r[0], 4);
        check("rc_sut10", r[2] - r[0], 8);
        check("rc_sut11", r[3] - r[0], 8);
        check("pll_sut01", p[1] - p[0], 4);
        check("pll_sut10", p[2] - p[0], 4);
        check("pll_sut11", p[3] - p[0], 8);
        check("prescale8", prescale_by_eight, 1'b1);
    endtask

    task automatic test_regs();
        logic [1:0] rs;
        start(4'h2, 2'b10, 1'b0, n);
        bus(0, 8'h0c, 0, rs);
        check("status", q[6:0], 7'h14);
        bus(0, 8'h04, 0, rs);
        check("cal_reset", q, 32'h80);
        bus(1, 8'h04, 32'h5a, rs); // kept below the 8 MHz setting
        check("cal", rc_calibration_value, 8'h5a);
        bus(0, 8'h10, 0, rs);
        check("unmapped_data", q, 32'h0);
        check("unmapped_resp", rs, 2'b10);
        bus(1, 8'h0c, 32'hff, rs);
        check("ro_write", rs, 2'b00);
    endtask

    task automatic test_pll();
        logic [1:0] rs;
        bus(1, 8'h00, 32'h2, rs);
        check("pll_on", gates.pll_on, 1'b1);
        n = 0;
        while (timer_fast_clock_ok !== 1'b1 && n < 50)
        begin
            @(negedge aclk);
            n++;
        end
        check("lock_time", n >= 2 && n < 10, 1'b1);
        bus(0, 8'h00, 0, rs);
        check("pll_reg", q[2:0], 3'b011);
        check("fast", pll_fast_khz, 17'd64000);
        check("sys", pll_sys_khz, 17'd16000);
        bus(1, 8'h00, 32'h6, rs);
        check("fast_low", pll_fast_khz, 17'd32000);
        check("halved", pll_ref_halved, 1'b1);
    endtask

    // every sleep mode: gating per mode, then wake by event
    task automatic test_sleep();
        logic [1:0] rs;
        for (int m = 0; m < 4; m++)
        begin
            bus(1, 8'h08, 32'h10 | m, rs);
            check("core", gates.core_clock, 1'b0);
            check("io", gates.peripheral_io_clock, m == 0);
            check("conv", gates.converter_clock, m < 2);
            check("osc", gates.rc_osc_on, m < 2);
            check("pll", gates.pll_on, m < 2);
            wake_event <= 1;
            @(posedge aclk);
            wake_event <= 0;
            n = 0;
            while (cpu_running !== 1'b1 && n < 30)
            begin
                @(negedge aclk);
                n++;
            end
            check("woken", cpu_running, 1'b1);
        end
    endtask

    // deep wake waits for source ticks; async input wakes idle
    task automatic test_wake();
        logic [1:0] rs;
        bus(1, 8'h08, 32'h12, rs);
        source_tick <= 0;
        wake_event <= 1;
        @(posedge aclk);
        wake_event <= 0;
        repeat (20) @(negedge aclk);
        check("no_ticks", cpu_running, 1'b0);
        @(posedge aclk);
        source_tick <= 1;
        n = 0;
        while (cpu_running !== 1'b1 && n < 30)
        begin
            @(negedge aclk);
            n++;
        end
        check("wake_len", n >= 5 && n <= 9 && base_n - n >= 14, 1'b1);
        bus(1, 8'h08, 32'h10, rs);
        async_int_in <= 2'b10;
        @(negedge aclk);
        check("async", async_int_wake, 1'b1);
        @(posedge aclk);
        async_int_in <= 0;
        @(negedge aclk);
        check("async_run", cpu_running, 1'b1);
    endtask

    task automatic test_select();
        logic [1:0] rs;
        start(4'h1, 2'b00, 1'b1, n);
        bus(1, 8'h00, 32'h4, rs);
        bus(0, 8'h00, 0, rs);
        check("low_speed", q[2], 1'b0);
        check("pll_fuse_on", gates.pll_on, 1'b1);
        check("sys16", pll_sys_khz, 17'd16000);
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        test_decode();
        test_startup();
        test_regs();
        test_pll();
        test_sleep();
        test_wake();
        test_select();
        finish_test();
    end
endmodule // clock_source_select_pll_bench

bind clock_source_select_pll clock_source_select_pll_assertions #(.ASYNC_INTS(ASYNC_INTS)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .async_int_in(async_int_in), .gates(gates),
    .sys_source(sys_source), .pll_ref_halved(pll_ref_halved), .pll_fast_khz(pll_fast_khz),
    .pll_sys_khz(pll_sys_khz), .timer_fast_clock_ok(timer_fast_clock_ok),
    .async_int_wake(async_int_wake));
